//--- alarm_pulse_gen.sv
// Single active-high pulse of fixed length on a start strobe
`timescale 1ns/1ps
`default_nettype none
module alarm_pulse_gen
  import rtc_special_regs_pkg::*;
#(
  parameter int unsigned LENGTH = PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // Control
  input  wire logic start_i,
  input  wire logic enable_i,
  output logic      pulse_o
);

  logic [PULSE_CNT_W-1:0] remaining;
  wire                    running = (remaining != '0);
  wire                    last    = (remaining == PULSE_CNT_W'(1));

  // Disable forces output low and aborts a pulse in flight
  always_ff @(posedge clock_i) begin
    if (srst_i || !enable_i) begin
      remaining <= '0;
      pulse_o   <= 1'b0;
    end else if (start_i && !running) begin
      remaining <= PULSE_CNT_W'(LENGTH);
      pulse_o   <= 1'b1;
    end else if (running) begin
      remaining <= remaining - PULSE_CNT_W'(1);
      pulse_o   <= !last;
    end
  end

endmodule : alarm_pulse_gen
`default_nettype wire

//--- charger_decode.sv
// Trickle charger selection decode from the charger register
`timescale 1ns/1ps
`default_nettype none
module charger_decode
  import rtc_special_regs_pkg::*;
(
  input  wire logic [7:0] select_i,
  output logic            enable_o,
  output logic            two_diodes_o,
  output logic [1:0]      resistor_o
);

  wire [3:0] key   = select_i[KEY_MSB:KEY_LSB];
  wire [1:0] diode = select_i[DIODE_MSB:DIODE_LSB];
  wire [1:0] res   = select_i[RES_MSB:RES_LSB];

  wire key_ok   = (key == CHARGER_KEY_OPEN);
  wire diode_ok = (diode == DIODE_ONE) || (diode == DIODE_TWO);
  wire res_ok   = (res != RES_OFF);

  assign enable_o     = key_ok && diode_ok && res_ok;
  assign two_diodes_o = (diode == DIODE_TWO);
  assign resistor_o   = res;

endmodule : charger_decode
`default_nettype wire

//--- host_port_model.sv
// Host side of the register port, one request at a time
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  // Register port
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  output logic [7:0]      addr_o,
  output logic            visit_o,
  output logic            write_o,
  output logic [7:0]      wdata_o
);
  initial begin
    addr_o = 8'h00;
    visit_o = 1'b0;
    write_o = 1'b0;
    wdata_o = 8'h00;
  end
  // callers clear protect alone before other writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_o = a | 8'h80;
    wdata_o = d;
    write_o = 1'b1;
    visit_o = 1'b1;
    @(negedge clock_i);
    write_o = 1'b0;
    visit_o = 1'b0;
    // Released data shows a changed value, not the last one
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    visit_o = 1'b1;
    @(negedge clock_i);
    visit_o = 1'b0;
    d = rdata_i;
  endtask : rd
endmodule : host_port_model
`default_nettype wire

//--- rtc_special_regs.sv
// Control, status and trickle charger registers of the serial clock
// Function
// - control read 0F, write 8F
// - write protect blocks register writes except to protect
// - protected control write changes only protect
// - tick enable drives or floats output
// - alarm A output low when flagged, enabled
// - alarm B disabled holds output low
// - alarm B flag gives 62.5 ms pulse
// - alarm A flag sets on any supply
// - alarm B flag sets off primary only
// - alarm A register visit clears flag
// - alarm B register visit clears flag
// - status read at 10, flags low bits
// - charger read 11, write 91
// - charger needs key 1010
// - charger resets to 5C, disabled
// - diode field one or two diodes
// - resistor field 2k 4k 8k
// - battery supply rejects all writes
// - secondary supply imposes no protection
// - match strobes set alarm flags
// - alarm A range 87 to 8A
// - alarm B range 8B to 8E
`timescale 1ns/1ps
`default_nettype none
module rtc_special_regs
  import rtc_special_regs_pkg::*;
#(
  parameter int unsigned PULSE_LENGTH = PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // Register port from the serial engine
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_visit_i,
  input  wire logic       reg_write_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  output logic            write_allowed_o,
  // Alarm comparison and time base
  input  wire logic       alarm_match_a_i,
  input  wire logic       alarm_match_b_i,
  input  wire logic       second_tick_i,
  // Supply switch
  input  wire logic [1:0] supply_source_i,
  // Pins
  output logic            second_tick_o,
  output logic            second_tick_oe_o,
  output logic            alarm_irq_out_a_n_o,
  output logic            alarm_irq_out_b_o,
  // Trickle charger controls
  output logic            charger_enable_o,
  output logic            charger_two_diodes_o,
  output logic [1:0]      charger_resistor_o
);

  // Register state
  logic       write_protect;
  logic       second_tick_output_enable;
  logic       alarm_irq_enable_a;
  logic       alarm_irq_enable_b;
  logic       alarm_flag_a;
  logic       alarm_flag_b;
  logic [7:0] charger_select;

  // Address decode, read direction ignores bit 7
  wire [7:0] rd_addr = reg_addr_i & ~WRITE_FLAG_MASK;
  wire       is_write_addr = (reg_addr_i & WRITE_FLAG_MASK) != 8'h00;

  wire on_battery = (supply_source_i == SUPPLY_BATTERY);
  // second flag needs non-primary; secondary has no lock
  wire off_primary = (supply_source_i == SUPPLY_SECONDARY) || on_battery;

  wire wr_ok = reg_write_i && is_write_addr && !on_battery;

  wire ctrl_wr    = wr_ok && (reg_addr_i == CONTROL_WR_ADDR);
  wire charger_wr = wr_ok && (reg_addr_i == CHARGER_WR_ADDR);

  // enables and charger frozen under protect
  wire ctrl_bits_wr = ctrl_wr && !write_protect;
  wire charger_upd  = charger_wr && !write_protect;

  wire in_alarm_a = reg_visit_i &&
                    (rd_addr >= ALARM_A_FIRST) && (rd_addr <= ALARM_A_LAST);
  wire in_alarm_b = reg_visit_i &&
                    (rd_addr >= ALARM_B_FIRST) && (rd_addr <= ALARM_B_LAST);

  wire set_a = alarm_match_a_i;
  wire set_b = alarm_match_b_i && off_primary;

  // Read mux, unmapped addresses return zero
  // spare control bits zero
  wire [7:0] ctrl_view = {1'b0, write_protect, 3'b000,
                          second_tick_output_enable,
                          alarm_irq_enable_b, alarm_irq_enable_a};
  wire [7:0] status_view = {6'b000000, alarm_flag_b, alarm_flag_a};
  wire       sel_ctrl    = (rd_addr == CONTROL_RD_ADDR);
  wire       sel_status  = (rd_addr == STATUS_RD_ADDR);
  wire       sel_charger = (rd_addr == CHARGER_RD_ADDR);
  wire [7:0] next_rdata  = sel_ctrl    ? ctrl_view :
                           sel_status  ? status_view :
                           sel_charger ? charger_select : 8'h00;

  // Protect bit stays writable so the host can unlock
  // protected write keeps enables
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      write_protect             <= WRITE_PROTECT_RST;
      second_tick_output_enable <= 1'b0;
      alarm_irq_enable_a        <= 1'b0;
      alarm_irq_enable_b        <= 1'b0;
    end else if (ctrl_wr) begin
      write_protect <= reg_wdata_i[WRITE_PROTECT_BIT];
      if (ctrl_bits_wr) begin
        second_tick_output_enable <= reg_wdata_i[TICK_ENABLE_BIT];
        alarm_irq_enable_b        <= reg_wdata_i[IRQ_ENABLE_B_BIT];
        alarm_irq_enable_a        <= reg_wdata_i[IRQ_ENABLE_A_BIT];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      alarm_flag_a <= 1'b0;
      alarm_flag_b <= 1'b0;
    end else begin
      alarm_flag_a <= set_a || (alarm_flag_a && !in_alarm_a);
      alarm_flag_b <= set_b || (alarm_flag_b && !in_alarm_b);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      charger_select <= CHARGER_RESET;
    end else if (charger_upd) begin
      charger_select <= reg_wdata_i;
    end
  end

  // Pulse on rising edge of flag B only
  logic flag_b_seen;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flag_b_seen <= 1'b0;
    end else begin
      flag_b_seen <= alarm_flag_b;
    end
  end
  wire flag_b_rise = alarm_flag_b && !flag_b_seen;

  alarm_pulse_gen #(
    .LENGTH   (PULSE_LENGTH)
  ) i_alarm_pulse_gen (
    .clock_i  (clock_i),
    .srst_i   (srst_i),
    .start_i  (flag_b_rise),
    .enable_i (alarm_irq_enable_b),
    .pulse_o  (alarm_irq_out_b_o)
  );

  logic       dec_enable;
  logic       dec_two;
  logic [1:0] dec_res;

  charger_decode i_charger_decode (
    .select_i     (charger_select),
    .enable_o     (dec_enable),
    .two_diodes_o (dec_two),
    .resistor_o   (dec_res)
  );

  // Registered outputs
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reg_rdata_o          <= 8'h00;
      write_allowed_o      <= 1'b0;
      second_tick_o        <= 1'b0;
      second_tick_oe_o     <= 1'b0;
      alarm_irq_out_a_n_o  <= 1'b1;
      charger_enable_o     <= 1'b0;
      charger_two_diodes_o <= 1'b0;
      charger_resistor_o   <= 2'b00;
    end else begin
      reg_rdata_o          <= next_rdata;
      write_allowed_o      <= !write_protect && !on_battery;
      second_tick_o        <= second_tick_i;
      second_tick_oe_o     <= second_tick_output_enable;
      // active low when flagged and enabled
      alarm_irq_out_a_n_o  <= !(alarm_flag_a && alarm_irq_enable_a);
      charger_enable_o     <= dec_enable;
      charger_two_diodes_o <= dec_two;
      charger_resistor_o   <= dec_res;
    end
  end

endmodule : rtc_special_regs
`default_nettype wire

//--- rtc_special_regs_chk.sv
// Port checker for the special register block
`timescale 1ns/1ps
`default_nettype none
module rtc_special_regs_chk
  import rtc_special_regs_pkg::*;
#(
  parameter int unsigned PULSE_LENGTH = PULSE_CYCLES
) (
  input wire logic       clock_i,
  input wire logic       srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_visit_i,
  input wire logic       reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       write_allowed_o,
  input wire logic       alarm_match_a_i,
  input wire logic       alarm_match_b_i,
  input wire logic       second_tick_i,
  input wire logic [1:0] supply_source_i,
  input wire logic       second_tick_o,
  input wire logic       alarm_irq_out_a_n_o,
  input wire logic       alarm_irq_out_b_o,
  input wire logic       charger_enable_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Counts high cycles; an aborted pulse would also trip this
  logic [PULSE_CNT_W-1:0] high_cnt;
  always_ff @(posedge clock_i) begin
    high_cnt <= (srst_i || !alarm_irq_out_b_o) ? '0 : high_cnt + 1'b1;
  end
  chk_status_zeros: assert property (reg_addr_i[6:0] == 7'h10
    |=> reg_rdata_o[7:2] == 6'h00) else $error("status high bits set");
  chk_ctl_zeros: assert property (reg_addr_i[6:0] == 7'h0F
    |=> !reg_rdata_o[7] && reg_rdata_o[5:3] == 3'h0) else $error("ctl bits");
  chk_batt_blocks: assert property (supply_source_i == 2'b10
    |=> !write_allowed_o) else $error("writes allowed on battery");
  chk_visit_releases: assert property (reg_visit_i && !alarm_match_a_i
    && reg_addr_i[6:0] inside {[7'h07:7'h0A]} |=> ##1 alarm_irq_out_a_n_o)
    else $error("alarm A output not released");
  chk_pulse_length: assert property ($fell(alarm_irq_out_b_o)
    |-> high_cnt == PULSE_LENGTH) else $error("alarm B pulse length");
  chk_pulse_bound: assert property (alarm_irq_out_b_o
    |-> high_cnt < PULSE_LENGTH) else $error("alarm B pulse too long");
  chk_pulse_cause: assert property ($rose(alarm_irq_out_b_o)
    |-> $past(alarm_match_b_i, 2) && $past(supply_source_i, 2) != 2'b00)
    else $error("alarm B pulse without cause");
  chk_key_needed: assert property ($rose(charger_enable_o)
    |-> $past(reg_write_i, 2) && $past(reg_addr_i, 2) == 8'h91
    && $past(reg_wdata_i[7:4], 2) == 4'hA) else $error("charger enabled");
  chk_tick_copy: assert property (!$past(srst_i)
    |-> second_tick_o == $past(second_tick_i)) else $error("tick copy");
  cover property ($rose(alarm_irq_out_b_o));
  cover property ($fell(alarm_irq_out_a_n_o));
  cover property ($rose(charger_enable_o));
endmodule : rtc_special_regs_chk
bind rtc_special_regs rtc_special_regs_chk #(.PULSE_LENGTH(PULSE_LENGTH))
  i_rtc_special_regs_chk (.clock_i, .srst_i, .reg_addr_i, .reg_visit_i,
  .reg_write_i, .reg_wdata_i, .reg_rdata_o, .write_allowed_o, .alarm_match_a_i,
  .alarm_match_b_i, .second_tick_i, .supply_source_i, .second_tick_o,
  .alarm_irq_out_a_n_o, .alarm_irq_out_b_o, .charger_enable_o);
`default_nettype wire

//--- rtc_special_regs_pkg.sv
// Package: offsets, fields, reset values and timing for special registers
package rtc_special_regs_pkg;

  // Register read and write addresses
  localparam logic [7:0] CONTROL_RD_ADDR   = 8'h0F;
  localparam logic [7:0] CONTROL_WR_ADDR   = 8'h8F;
  localparam logic [7:0] STATUS_RD_ADDR    = 8'h10;
  localparam logic [7:0] CHARGER_RD_ADDR   = 8'h11;
  localparam logic [7:0] CHARGER_WR_ADDR   = 8'h91;
  localparam logic [7:0] ALARM_A_FIRST     = 8'h07;
  localparam logic [7:0] ALARM_A_LAST      = 8'h0A;
  localparam logic [7:0] ALARM_B_FIRST     = 8'h0B;
  localparam logic [7:0] ALARM_B_LAST      = 8'h0E;
  localparam logic [7:0] WRITE_FLAG_MASK   = 8'h80;

  // Control register fields
  localparam int WRITE_PROTECT_BIT = 6;
  localparam int TICK_ENABLE_BIT   = 2;
  localparam int IRQ_ENABLE_B_BIT  = 1;
  localparam int IRQ_ENABLE_A_BIT  = 0;

  // Charger register fields
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 4;
  localparam int DIODE_MSB = 3;
  localparam int DIODE_LSB = 2;
  localparam int RES_MSB = 1;
  localparam int RES_LSB = 0;
  localparam logic [3:0] CHARGER_KEY_OPEN  = 4'hA;
  localparam logic [1:0] DIODE_ONE         = 2'h1;
  localparam logic [1:0] DIODE_TWO         = 2'h2;
  localparam logic [1:0] RES_OFF           = 2'h0;

  // Values after reset
  localparam logic [7:0] CHARGER_RESET     = 8'h5C;
  localparam logic       WRITE_PROTECT_RST = 1'b1;

  // Supply source encoding
  typedef enum logic [1:0] {
    SUPPLY_PRIMARY   = 2'b00,
    SUPPLY_SECONDARY = 2'b01,
    SUPPLY_BATTERY   = 2'b10
  } supply_t;

  // Pulse timing
  localparam int CLOCK_HZ         = 10_000_000;
  localparam int PULSE_TIME_US    = 62_500;
  localparam int PULSE_CYCLES     = (PULSE_TIME_US * (CLOCK_HZ / 1_000_000));
  localparam int PULSE_CNT_W      = 20;

endpackage : rtc_special_regs_pkg

//--- test_rtc_alarm_control_status_regs.sv
// Self-checking bench for the special register block
`timescale 1ns/1ps
`default_nettype none
module test_rtc_alarm_control_status_regs;
  import rtc_special_regs_pkg::*;
  localparam int unsigned PL = 8;
  logic clock_i = 1'b0, srst_i = 1'b1, second_tick_i = 1'b0;
  logic alarm_match_a_i = 1'b0, alarm_match_b_i = 1'b0;
  logic [1:0] supply_source_i = 2'b00, res;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
  logic reg_visit_i, reg_write_i, ok, tick, oe, irq_a_n, irq_b, en, two;
  logic [7:0] cv [10] = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB,
                          8'hA4, 8'hAC, 8'hA0, 8'h5D};
  int error_cnt = 0, comparisons = 0, n;
  always #50 clock_i = ~clock_i;
  always #400 second_tick_i = ~second_tick_i;
  rtc_special_regs #(.PULSE_LENGTH(PL)) i_rtc_special_regs (.clock_i,
    .srst_i, .reg_addr_i, .reg_visit_i, .reg_write_i, .reg_wdata_i,
    .reg_rdata_o, .write_allowed_o(ok), .alarm_match_a_i, .alarm_match_b_i,
    .second_tick_i, .supply_source_i, .second_tick_o(tick),
    .second_tick_oe_o(oe), .alarm_irq_out_a_n_o(irq_a_n),
    .alarm_irq_out_b_o(irq_b), .charger_enable_o(en),
    .charger_two_diodes_o(two), .charger_resistor_o(res));
  host_port_model i_host_port_model (.clock_i, .rdata_i(reg_rdata_o),
    .addr_o(reg_addr_i), .visit_o(reg_visit_i), .write_o(reg_write_i),
    .wdata_o(reg_wdata_i));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_host_port_model.rd(a, rv);
    check(rv, exp);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_port_model.wr(a, d);
  endtask : wr
  task automatic strobe(input logic b);
    @(negedge clock_i);
    alarm_match_a_i = !b;
    alarm_match_b_i = b;
    @(negedge clock_i);
    alarm_match_a_i = 1'b0;
    alarm_match_b_i = 1'b0;
  endtask : strobe
  function automatic logic exp_en(input logic [7:0] v);
    return v[7:4] == 4'hA && v[3] != v[2] && v[1:0] != 2'h0;
  endfunction : exp_en
  task automatic final_report;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Whole run is under 400 cycles
  initial begin
    #(100 * 3000);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clock_i);
    srst_i = 1'b0;
    rdc(8'h0F, 8'h40);
    rdc(8'h11, CHARGER_RESET);
    check({7'h00, en}, 8'h00);
    wr(8'h0F, 8'h47);
    rdc(8'h0F, 8'h40);
    wr(8'h11, 8'hA5);
    rdc(8'h11, CHARGER_RESET);
    wr(8'h0F, 8'h00);
    wr(8'h0F, 8'hBF);
    rdc(8'h0F, 8'h07);
    check({7'h00, oe}, 8'h01);
    foreach (cv[i]) begin
      wr(8'h11, cv[i]);
      rdc(8'h11, cv[i]);
      check({7'h00, en}, {7'h00, exp_en(cv[i])});
      if (exp_en(cv[i])) check({5'h00, two, res}, {5'h00, cv[i][3], cv[i][1:0]});
    end
    wr(8'h11, 8'hA9);
    supply_source_i = SUPPLY_BATTERY;
    wr(8'h11, 8'h5C);
    wr(8'h0F, 8'h00);
    rdc(8'h11, 8'hA9);
    rdc(8'h0F, 8'h07);
    check({7'h00, ok}, 8'h00);
    supply_source_i = SUPPLY_SECONDARY;
    wr(8'h0F, 8'h03);
    rdc(8'h0F, 8'h03);
    check({7'h00, ok, oe}, 8'h02);
    supply_source_i = SUPPLY_BATTERY;
    strobe(1'b0);
    @(negedge clock_i);
    check({7'h00, irq_a_n}, 8'h00);
    rdc(8'h10, 8'h01);
    i_host_port_model.rd(8'h08, rv);
    rdc(8'h10, 8'h00);
    check({7'h00, irq_a_n}, 8'h01);
    strobe(1'b0);
    wr(8'h0A, 8'h00);
    rdc(8'h10, 8'h00);
    supply_source_i = SUPPLY_SECONDARY;
    strobe(1'b0);
    wr(8'h0F, 8'h02);
    @(negedge clock_i);
    check({7'h00, irq_a_n}, 8'h01);
    i_host_port_model.rd(8'h09, rv);
    supply_source_i = SUPPLY_PRIMARY;
    strobe(1'b1);
    rdc(8'h10, 8'h00);
    supply_source_i = SUPPLY_SECONDARY;
    strobe(1'b1);
    for (n = 0; n < 10 && !irq_b; n++) @(negedge clock_i);
    for (n = 0; n < 20 && irq_b; n++) @(negedge clock_i);
    check(8'(n), 8'(PL));
    rdc(8'h10, 8'h02);
    i_host_port_model.rd(8'h0D, rv);
    rdc(8'h10, 8'h00);
    wr(8'h0F, 8'h00);
    strobe(1'b1);
    repeat (PL + 4) begin
      @(negedge clock_i);
      check({7'h00, irq_b}, 8'h00);
    end
    rdc(8'h10, 8'h02);
    wr(8'h0E, 8'h00);
    rdc(8'h10, 8'h00);
    final_report();
  end
endmodule : test_rtc_alarm_control_status_regs
`default_nettype wire
